// File: logic/spm_master.sv
//Operation
//- serial clock period is peripheral clock over field plus one, or four
//- even divide or field 0/2: period 4 to 128 cycles, equal phases
//- odd divide, field above 3: period 5 to 127 cycles
//- odd divide: first phase half cycle short, second half cycle long
//- controller-select bit makes the unit bus master driving the clock
//- clock phase bit picks no-delay or half-cycle-advanced data scheme
//- polarity bit sets idle level and inverts every edge relation
//- phase 0: launch outgoing bit on rising edge, hold past falling
//- phase 0: sample incoming bit on falling edge
//- phase 1: place outgoing bit half period before rising edge
//- phase 1: sample incoming bit on rising edge
//- select asserted at least half period before first clock edge
//- select released half period after last sampling edge
//- select stays asserted between back-to-back words
`timescale 1ns/100ps
`default_nettype none
module spm_master
    import spm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    input  wire logic              controller_select,
    input  wire logic              clock_phase,
    input  wire logic              clock_polarity,
    input  wire logic [DIV_W-1:0]  baud_divider_field,
    input  wire logic              tx_valid,
    output var  logic              tx_ready,
    input  wire logic [WORD_W-1:0] tx_data,
    output var  logic              rx_valid,
    output var  logic [WORD_W-1:0] rx_data,
    output var  logic              busy,
    output var  logic              serial_clock_pin,
    output var  logic              serial_clock_oe,
    output var  logic              controller_out_data_pin,
    input  wire logic              controller_in_data_pin,
    output var  logic              slave_select_pin_b
);
    typedef struct packed {
        spm_state_e        st;
        logic              cpha;
        logic              cpol;
        logic [HALF_W-1:0] h1;
        logic [HALF_W-1:0] h2;
        logic [CNT_W-1:0]  cnt;
        logic              half;
        logic [BIT_W-1:0]  bit_cnt;
        logic [WORD_W-1:0] tx_sh;
        logic [WORD_W-1:0] rx_sh;
        logic              sclk;
        logic              sclk_oe;
        logic              mosi;
        logic              sel_b;
        logic              rx_valid;
        logic [WORD_W-1:0] rx_data;
        logic              busy;
    } spm_master_s;

    spm_master_s  s;
    spm_master_s  next_s;
    spm_stream_if txq ();
    logic         take;
    logic [7:0]   div;
    logic [7:0]   h1_full;

    // **********************************************
    // transmit queue
    // **********************************************
    spm_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_txq (
        .clk      (clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .in_valid (tx_valid),
        .in_ready (tx_ready),
        .in_data  (tx_data),
        .out      (txq.src)
    );

    assign txq.ready = take;

    // **********************************************
    // clock generation and framing
    // **********************************************
    always_comb begin
        next_s          = s;
        next_s.rx_valid = 1'b0;
        take            = 1'b0;
        div             = spm_div_value(baud_divider_field);
        h1_full         = {1'b0, div[7:1]};
        if (!controller_select) begin
            // slave side is not built here: park the pins
            next_s.st      = SPM_IDLE;
            next_s.sclk    = clock_polarity;
            next_s.sclk_oe = 1'b0;
            next_s.sel_b   = 1'b1;
            next_s.busy    = 1'b0;
        end else begin
            next_s.sclk_oe = 1'b1;
            case (s.st)
                SPM_IDLE: begin
                    next_s.sclk  = clock_polarity;
                    next_s.sel_b = 1'b1;
                    if (txq.valid) begin
                        take           = 1'b1;
                        next_s.cpha    = clock_phase;
                        next_s.cpol    = clock_polarity;
                        next_s.h1      = h1_full[HALF_W-1:0];
                        next_s.h2      = HALF_W'(div - h1_full);
                        next_s.cnt     = CNT_W'(HALF_W'(div - h1_full) - 1'b1);
                        next_s.sel_b   = 1'b0;
                        next_s.busy    = 1'b1;
                        next_s.bit_cnt = '0;
                        next_s.st      = SPM_LEAD;
                        if (clock_phase) begin
                            next_s.mosi  = txq.data[WORD_W-1];
                            next_s.tx_sh = {txq.data[WORD_W-2:0], 1'b0};
                        end else begin
                            next_s.tx_sh = txq.data;
                        end
                    end
                end
                SPM_LEAD: begin
                    if (s.cnt == '0) begin
                        // lead lasts the second half, never less than half a period
                        next_s.st   = SPM_SHIFT;
                        next_s.half = 1'b0;
                        next_s.cnt  = CNT_W'(s.h1 - 1'b1);
                        next_s.sclk = ~s.cpol;
                        if (!s.cpha) begin
                            next_s.mosi  = s.tx_sh[WORD_W-1];
                            next_s.tx_sh = {s.tx_sh[WORD_W-2:0], 1'b0};
                        end else begin
                            next_s.rx_sh = {s.rx_sh[WORD_W-2:0], controller_in_data_pin};
                        end
                    end else begin
                        next_s.cnt = CNT_W'(s.cnt - 1'b1);
                    end
                end
                SPM_SHIFT: begin
                    if (s.cnt != '0) begin
                        next_s.cnt = CNT_W'(s.cnt - 1'b1);
                    end else if (!s.half) begin
                        // end of first phase: trailing edge
                        next_s.sclk = s.cpol;
                        if (s.cpha && s.bit_cnt == LAST_BIT) begin
                            // phase 1 word ends half a period after its rising sample
                            if (txq.valid) begin
                                take           = 1'b1;
                                // wraps to zero at the new word's first rising sample
                                next_s.bit_cnt = LAST_BIT;
                                next_s.half    = 1'b1;
                                next_s.cnt     = CNT_W'(s.h2 - 1'b1);
                                next_s.mosi    = txq.data[WORD_W-1];
                                next_s.tx_sh   = {txq.data[WORD_W-2:0], 1'b0};
                            end else begin
                                next_s.st    = SPM_IDLE;
                                next_s.sel_b = 1'b1;
                                next_s.busy  = 1'b0;
                            end
                        end else begin
                            next_s.half = 1'b1;
                            next_s.cnt  = CNT_W'(s.h2 - 1'b1);
                            if (s.cpha) begin
                                next_s.mosi  = s.tx_sh[WORD_W-1];
                                next_s.tx_sh = {s.tx_sh[WORD_W-2:0], 1'b0};
                            end else begin
                                next_s.rx_sh = {s.rx_sh[WORD_W-2:0], controller_in_data_pin};
                                if (s.bit_cnt == LAST_BIT) begin
                                    next_s.rx_valid = 1'b1;
                                    next_s.rx_data  = {s.rx_sh[WORD_W-2:0],
                                                       controller_in_data_pin};
                                end
                            end
                        end
                    end else begin
                        // end of second phase: leading edge of next bit
                        if (s.bit_cnt == LAST_BIT && !s.cpha) begin
                            // phase 0 only gets here: word ends, or leads into a queued word
                            if (txq.valid) begin
                                take           = 1'b1;
                                next_s.bit_cnt = '0;
                                next_s.half    = 1'b0;
                                next_s.cnt     = CNT_W'(s.h1 - 1'b1);
                                next_s.sclk    = ~s.cpol;
                                next_s.mosi    = txq.data[WORD_W-1];
                                next_s.tx_sh   = {txq.data[WORD_W-2:0], 1'b0};
                            end else begin
                                next_s.st    = SPM_IDLE;
                                next_s.sel_b = 1'b1;
                                next_s.busy  = 1'b0;
                            end
                        end else begin
                            next_s.bit_cnt = BIT_W'(s.bit_cnt + 1'b1);
                            next_s.half    = 1'b0;
                            next_s.cnt     = CNT_W'(s.h1 - 1'b1);
                            next_s.sclk    = ~s.cpol;
                            if (!s.cpha) begin
                                next_s.mosi  = s.tx_sh[WORD_W-1];
                                next_s.tx_sh = {s.tx_sh[WORD_W-2:0], 1'b0};
                            end else begin
                                next_s.rx_sh = {s.rx_sh[WORD_W-2:0],
                                                controller_in_data_pin};
                                if (s.bit_cnt + 1'b1 == LAST_BIT) begin
                                    next_s.rx_valid = 1'b1;
                                    next_s.rx_data  = {s.rx_sh[WORD_W-2:0],
                                                       controller_in_data_pin};
                                end
                            end
                        end
                    end
                end
                default: begin
                    next_s.st = SPM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s       <= '0;
            s.st    <= SPM_IDLE;
            s.h1    <= HALF_RST;
            s.h2    <= HALF_RST;
            s.cnt   <= CNT_RST;
            s.tx_sh <= WORD_RST;
            s.sel_b <= SEL_B_RST;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // **********************************************
    // outputs, all from the state flops
    // **********************************************
    assign rx_valid                = s.rx_valid;
    assign rx_data                 = s.rx_data;
    assign busy                    = s.busy;
    assign serial_clock_pin        = s.sclk;
    assign serial_clock_oe         = s.sclk_oe;
    assign controller_out_data_pin = s.mosi;
    assign slave_select_pin_b      = s.sel_b;
endmodule
`default_nettype wire

// File: shared/spm_pkg.sv
`default_nettype none
package spm_pkg;
    // **********************************************
    // word and buffer shape
    // **********************************************
    localparam int WORD_W     = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int DIV_W      = 7;
    localparam int HALF_W     = 7;
    localparam int CNT_W      = 6;
    localparam int BIT_W      = 4;

    // **********************************************
    // serial clock divider
    // **********************************************
    localparam logic [7:0]       DIV_MIN       = 8'h04;
    localparam logic [DIV_W-1:0] FIELD_DIV_MIN = 7'h03;
    localparam logic [BIT_W-1:0] LAST_BIT      = 4'hf;

    // **********************************************
    // reset values
    // **********************************************
    localparam logic [WORD_W-1:0] WORD_RST   = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_RST    = 6'h00;
    localparam logic [HALF_W-1:0] HALF_RST   = 7'h02;
    localparam logic              SEL_B_RST  = 1'b1;

    typedef enum logic [1:0] {
        SPM_IDLE,
        SPM_LEAD,
        SPM_SHIFT
    } spm_state_e;

    // divide value: field plus one, or four for the smallest settings
    function automatic logic [7:0] spm_div_value(input logic [DIV_W-1:0] field);
        logic [7:0] d;
        d = {1'b0, field} + 8'h01;
        if (field < FIELD_DIV_MIN) begin
            d = DIV_MIN;
        end
        return d;
    endfunction
endpackage
`default_nettype wire

// File: shared/spm_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface spm_stream_if;
    import spm_pkg::*;
    logic              valid;
    logic              ready;
    logic [WORD_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: logic/spm_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module spm_fifo
    import spm_pkg::*;
#(
    parameter int W     = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    spm_stream_if.src         out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
        logic                    room;
        logic                    out_valid;
        logic [W-1:0]            out_data;
    } spm_fifo_s;

    spm_fifo_s s;
    spm_fifo_s next_s;
    logic      push;
    logic      load;
    logic      drain;

    // **********************************************
    // storage with a registered output stage
    // **********************************************
    always_comb begin
        next_s = s;
        push   = in_valid && s.room;
        drain  = s.out_valid && out.ready;
        load   = (s.cnt != '0) && (!s.out_valid || drain);
        if (push) begin
            next_s.mem[s.wr] = in_data;
            next_s.wr        = AW'(s.wr + 1'b1);
        end
        if (load) begin
            next_s.out_data  = s.mem[s.rd];
            next_s.out_valid = 1'b1;
            next_s.rd        = AW'(s.rd + 1'b1);
        end else if (drain) begin
            next_s.out_valid = 1'b0;
        end
        next_s.cnt  = (AW+1)'(s.cnt + {AW'(0), push} - {AW'(0), load});
        // room flag kept in a flop so the filling side sees a clean ready
        next_s.room = (next_s.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s      <= '0;
            s.room <= 1'b1;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign in_ready  = s.room;
    assign out.valid = s.out_valid;
    assign out.data  = s.out_data;
endmodule
`default_nettype wire

// File: tb/spm_master_chk.sv
`timescale 1ns/100ps
`default_nettype none
module spm_master_chk
    import spm_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst_b,
    input wire logic             clk_en,
    input wire logic             controller_select,
    input wire logic             clock_phase,
    input wire logic             clock_polarity,
    input wire logic [DIV_W-1:0] baud_divider_field,
    input wire logic             rx_valid,
    input wire logic             busy,
    input wire logic             serial_clock_pin,
    input wire logic             serial_clock_oe,
    input wire logic             controller_out_data_pin,
    input wire logic             slave_select_pin_b
);
    // ****
    // phase span counter
    // ****
    logic [7:0]       dv, h1, h2, run;
    logic [1:0]       prev;
    logic             en_q, ph_q, pol_q;
    logic [DIV_W-1:0] fld_q;
    assign dv = (fld_q < 7'h03) ? 8'h04 : {1'b0, fld_q} + 8'h01;
    assign h1 = {1'b0, dv[7:1]};
    assign h2 = dv - h1;
    // counts only edges that the design really took, so a clk_en stall does not skew it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 2'h1;
            run  <= 8'h00;
            en_q <= 1'b0;
            ph_q  <= 1'b0;
            pol_q <= 1'b0;
            fld_q <= 7'h00;
        end else begin
            prev <= {serial_clock_pin, slave_select_pin_b};
            en_q <= clk_en;
            // settings are taken at the edge where select falls, not live
            if (slave_select_pin_b) begin
                ph_q  <= clock_phase;
                pol_q <= clock_polarity;
                fld_q <= baud_divider_field;
            end
            if ({serial_clock_pin, slave_select_pin_b} != prev) begin
                run <= 8'h01;
            end else if (en_q) begin
                run <= run + 8'h01;
            end
        end
    end
    // ****
    // assertions
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    AST_OE_FOLLOW: assert property (clk_en |=> serial_clock_oe == $past(controller_select))
        else $error("clock enable output off");
    AST_IDLE_PHASE: assert property (
        $changed(serial_clock_pin) && !$past(slave_select_pin_b)
        && serial_clock_pin != pol_q |-> run == h2)
        else $error("idle-level phase length off");
    AST_ACTIVE_PHASE: assert property (
        $changed(serial_clock_pin) && !$past(slave_select_pin_b)
        && serial_clock_pin == pol_q |-> run == h1)
        else $error("active-level phase length off");
    AST_REL_PH0: assert property ($rose(slave_select_pin_b) && !ph_q |-> run == h2)
        else $error("select release late or early");
    AST_REL_PH1: assert property (
        $rose(slave_select_pin_b) && ph_q |-> $changed(serial_clock_pin)
        && serial_clock_pin == pol_q)
        else $error("select release not on last fall");
    AST_RX_EDGE: assert property (
        rx_valid |-> $changed(serial_clock_pin) && serial_clock_pin == (pol_q ^ ph_q))
        else $error("word end not on sampling edge");
    AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
        else $error("rx pulse too long");
    AST_MOSI_EDGE: assert property (
        $changed(controller_out_data_pin) && !slave_select_pin_b && !$past(slave_select_pin_b)
        |-> $changed(serial_clock_pin) && serial_clock_pin == (pol_q ^ ~ph_q))
        else $error("data out moved on wrong edge");
    AST_BUSY_SEL: assert property (busy != slave_select_pin_b)
        else $error("busy and select disagree");
endmodule
bind spm_master spm_master_chk u_chk (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .controller_select(controller_select),
    .clock_phase(clock_phase), .clock_polarity(clock_polarity),
    .baud_divider_field(baud_divider_field), .rx_valid(rx_valid), .busy(busy),
    .serial_clock_pin(serial_clock_pin), .serial_clock_oe(serial_clock_oe),
    .controller_out_data_pin(controller_out_data_pin), .slave_select_pin_b(slave_select_pin_b)
);
`default_nettype wire

// File: tb/spm_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module spm_slave_model
    import spm_pkg::*;
(
    input  wire logic              serial_clock_pin,
    input  wire logic              slave_select_pin_b,
    input  wire logic              controller_out_data_pin,
    input  wire logic              clock_phase,
    input  wire logic              clock_polarity,
    input  wire logic [WORD_W-1:0] reply,
    output var  logic              controller_in_data_pin,
    output var  logic [WORD_W-1:0] got
);
    logic [BIT_W-1:0] idx;
    logic             adv;
    initial begin
        controller_in_data_pin = 1'b0;
        got = WORD_RST;
        idx = LAST_BIT;
        adv = 1'b0;
    end
    // first bit stands from select fall, ahead of the first sampling edge
    always @(negedge slave_select_pin_b) begin
        idx = LAST_BIT;
        adv = 1'b0;
        controller_in_data_pin = reply[idx];
    end
    // line inverts on release: a released slave never holds its last bit stale
    always @(posedge slave_select_pin_b) begin
        controller_in_data_pin = ~controller_in_data_pin;
    end
    always @(serial_clock_pin) begin
        if (!slave_select_pin_b) begin
            if ((serial_clock_pin != clock_polarity) == clock_phase) begin
                got = {got[WORD_W-2:0], controller_out_data_pin};
                adv = 1'b1;
            end else if (adv) begin
                idx = idx - 4'h1;
                adv = 1'b0;
                controller_in_data_pin = reply[idx];
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/spi_master_clock_and_framing_bench.sv
`timescale 1ns/100ps
`default_nettype none
module spi_master_clock_and_framing_bench;
    import spm_pkg::*;
    logic              clk, rst_b, clk_en, controller_select, clock_phase, clock_polarity;
    logic [DIV_W-1:0]  baud_divider_field;
    logic              tx_valid, tx_ready, rx_valid, busy, serial_clock_pin, serial_clock_oe;
    logic              controller_out_data_pin, controller_in_data_pin, slave_select_pin_b;
    logic [WORD_W-1:0] tx_data, rx_data, reply, got;
    int                n_mismatch, check_count;

    spm_master u_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .controller_select(controller_select), .clock_phase(clock_phase),
        .clock_polarity(clock_polarity), .baud_divider_field(baud_divider_field),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_data(rx_data), .busy(busy), .serial_clock_pin(serial_clock_pin),
        .serial_clock_oe(serial_clock_oe), .controller_out_data_pin(controller_out_data_pin),
        .controller_in_data_pin(controller_in_data_pin), .slave_select_pin_b(slave_select_pin_b));
    spm_slave_model u_slave (.serial_clock_pin(serial_clock_pin),
        .slave_select_pin_b(slave_select_pin_b), .controller_out_data_pin(controller_out_data_pin),
        .clock_phase(clock_phase), .clock_polarity(clock_polarity), .reply(reply),
        .controller_in_data_pin(controller_in_data_pin), .got(got));

    // ****
    // shared helpers
    // ****
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // counts cycles from select fall to release, noting the receive pulses
    task automatic watch_frame(output int c, output int c_rx, output int n_rx);
        c = 0;
        c_rx = 0;
        n_rx = 0;
        while (slave_select_pin_b !== 1'b0 && c < 40) begin
            @(negedge clk);
            c++;
        end
        c = 0;
        while (slave_select_pin_b === 1'b0 && c < 2400) begin
            @(negedge clk);
            c++;
            if (rx_valid === 1'b1) begin
                c_rx = c;
                n_rx++;
            end
        end
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_word_mode(input logic ph, input logic pol, input logic [DIV_W-1:0] f,
                               input logic [WORD_W-1:0] w);
        int d, h1, c, c_rx, n_rx;
        d = (f < 3) ? 4 : f + 1;
        h1 = d / 2;
        clock_phase = ph;
        clock_polarity = pol;
        baud_divider_field = f;
        reply = ~w;
        tx_data = w;
        tx_valid = 1'b1;
        @(negedge clk);
        tx_valid = 1'b0;
        watch_frame(c, c_rx, n_rx);
        check("rx cycle", ph ? 16 * d - h1 : 16 * d, c_rx);
        check("release cycle", ph ? 16 * d : 17 * d - h1, c);
        check("rx word", reply, rx_data);
        check("slave word", w, got);
        check("idle level", pol, serial_clock_pin);
    endtask
    task automatic t_fill_drain();
        int n, c, c_rx, n_rx;
        n = 0;
        controller_select = 1'b0;
        clock_phase = 1'b0;
        clock_polarity = 1'b0;
        baud_divider_field = 7'h00;
        reply = 16'h0ff0;
        repeat (24) begin
            @(negedge clk);
            tx_valid = 1'b1;
            tx_data = 16'h1000 + n[15:0];
            if (tx_ready === 1'b1) n++;
        end
        @(negedge clk);
        tx_valid = 1'b0;
        check("words taken", 17, n);
        clk_en = 1'b0;
        controller_select = 1'b1;
        repeat (10) @(negedge clk);
        check("frozen select", 1, slave_select_pin_b);
        check("frozen oe", 0, serial_clock_oe);
        clk_en = 1'b1;
        watch_frame(c, c_rx, n_rx);
        check("burst length", 17 * 64 + 2, c);
        check("words sent", 17, n_rx);
        check("last word", 16'h1010, got);
        check("rx word", reply, rx_data);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(20000 * 100);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        controller_select = 1'b1;
        clock_phase = 1'b0;
        clock_polarity = 1'b0;
        baud_divider_field = 7'h00;
        tx_valid = 1'b0;
        tx_data = 16'h0000;
        reply = 16'h0000;
        n_mismatch = 0;
        check_count = 0;
        repeat (3) @(negedge clk);
        check("select in reset", 1, slave_select_pin_b);
        check("ready in reset", 1, tx_ready);
        rst_b = 1'b1;
        @(negedge clk);
        check("oe after reset", 1, serial_clock_oe);
        t_word_mode(1'b0, 1'b0, 7'h00, 16'ha55a);
        t_word_mode(1'b1, 1'b0, 7'h02, 16'h8001);
        t_word_mode(1'b0, 1'b1, 7'h04, 16'h3cc3);
        t_word_mode(1'b1, 1'b1, 7'h03, 16'h7ffe);
        t_word_mode(1'b0, 1'b1, 7'h7e, 16'hc35a);
        t_word_mode(1'b1, 1'b0, 7'h7f, 16'h5aa5);
        t_fill_drain();
        print_verdict();
    end
endmodule
`default_nettype wire
